// ---- core/rsd_pkg.sv ----
// Purpose: shared constants and types for the remote serial display link
// Assumes: one 20 MHz system clock on both ends
// Notes: all counts are in ref_clk cycles unless named otherwise
package rsd_pkg;

  // ******************************
  // clock and link timing
  // ******************************
  localparam int CLK_NS = 50;
  localparam int ENTRY_CLK_NS = 400;
  localparam int ENTRY_DIV = (ENTRY_CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int ENTRY_HALF = ENTRY_DIV / 2;
  localparam int DISP_CLK_NS = 1000;
  localparam int DISP_DIV = (DISP_CLK_NS + CLK_NS - 1) / CLK_NS;

  // ******************************
  // frame geometry
  // ******************************
  localparam int CODE_BITS = 5;
  localparam int COLUMNS = 5;
  localparam int ROWS_PER_CHAR = 7;
  localparam int CHARS_PER_PKG = 4;
  localparam int PKG_BITS = ROWS_PER_CHAR * CHARS_PER_PKG;
  localparam int DEF_PACKAGES = 1;

  // ******************************
  // refresh timing
  // ******************************
  // display time is SHOW_RATIO times the shift time of a column: 7/8 lit share
  localparam int SHOW_RATIO = 7;
  localparam int DUTY_MAX_PCT = 20;
  localparam int REFRESH_MIN_HZ = 100;
  localparam int BUF_DEPTH = 2;

  // ******************************
  // state types
  // ******************************
  typedef enum logic [1:0] {
    ST_SHIFT = 2'b00,
    ST_SHOW = 2'b01,
    ST_LOAD = 2'b10
  } rsd_dev_state_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_REQ = 2'b01,
    H_SHIFT = 2'b10,
    H_END = 2'b11
  } rsd_host_state_type;

endpackage : rsd_pkg

// ---- core/rsd_link_if.sv ----
// Purpose: wires between the sending host and the display end
// Assumes: every signal is a plain one-way level
// Notes: the host makes the entry clock; the display end samples it
`timescale 1ns/10ps
interface rsd_link_if;
  // active low load request, host to display
  logic loadDataN;
  // entry clock, host to display
  logic entryClk;
  // serial frame bit, host to display
  logic serData;
  // active low ready, display to host
  logic readyN;

  modport dev_mp (
    input loadDataN,
    input entryClk,
    input serData,
    output readyN
  );

  modport host_mp (
    output loadDataN,
    output entryClk,
    output serData,
    input readyN
  );
endinterface : rsd_link_if

// ---- core/rsd_display_end.sv ----
// Purpose: display end: frame storage, loading, column refresh and lit period
// Assumes: entry clock and load request arrive asynchronously from the host
// Notes: display clock is a divider tick of ref_clk, taken as its falling edge
`timescale 1ns/10ps

// Behaviour
// - host sends 35N+25 bits per load
// - stream is five equal column subsets
// - subset: 5-bit column code, then 7N rows
// - separate entry clock and display clock
// - load low, ready low, then shifting
// - serial data enters only while loading
// - load ends with code in column register
// - load high returns clocking to display clock
// - shift 7N+5 bits, then show for T
// - period starts on next display falling edge
// - counter held reset while period runs
// - lit duty factor at most 20 percent
// - one in row stage lights its LED
// - bits are taken on falling clock edges
// - each package adds 28 row bits
// - each column revisited at least 100 Hz
module rsd_display_end #(
  parameter int PACKAGES = rsd_pkg::DEF_PACKAGES,
  parameter int SHOW_CYCLES = rsd_pkg::SHOW_RATIO * rsd_pkg::DISP_DIV
    * (rsd_pkg::PKG_BITS * PACKAGES + rsd_pkg::CODE_BITS)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link to host
  rsd_link_if.dev_mp link,
  // display drive
  output logic [rsd_pkg::PKG_BITS*PACKAGES-1:0] rowSink,
  output logic [rsd_pkg::CODE_BITS-1:0] colDrive,
  output logic lit,
  // status
  output logic loading,
  output logic loadErr
);
  import rsd_pkg::*;

  // ******************************
  // sizes
  // ******************************
  localparam int ROWS = PKG_BITS * PACKAGES;
  localparam int SUB = ROWS + CODE_BITS;
  localparam int TOTAL = COLUMNS * SUB;
  localparam int SCW = $clog2(SUB + 1);
  localparam int TW = $clog2(SHOW_CYCLES + 1);
  localparam int DW = $clog2(DISP_DIV + 1);
  localparam int LW = $clog2(TOTAL + 2);

  // ******************************
  // input synchronisers
  // ******************************
  logic [1:0] loadSync;
  logic [1:0] clkSync;
  logic [1:0] dataSync;
  logic clkPrev;
  logic entryFall;
  logic loadReq;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loadSync <= 2'h3;
      clkSync <= 2'h0;
      dataSync <= 2'h0;
      clkPrev <= 1'b0;
    end else begin
      loadSync <= {loadSync[0], link.loadDataN};
      clkSync <= {clkSync[0], link.entryClk};
      dataSync <= {dataSync[0], link.serData};
      clkPrev <= clkSync[1];
    end
  end

  // entry clock kept as its own rate, found by edge on the sampled level
  assign entryFall = clkPrev & ~clkSync[1];
  assign loadReq = ~loadSync[1];

  // ******************************
  // display clock divider
  // ******************************
  logic [DW-1:0] dispCnt;
  logic [DW-1:0] next_dispCnt;
  logic dispTick;

  assign dispTick = (dispCnt == DW'(DISP_DIV - 1));

  always_comb begin
    next_dispCnt = dispTick ? '0 : dispCnt + DW'(1);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dispCnt <= '0;
    end else begin
      dispCnt <= next_dispCnt;
    end
  end

  // ******************************
  // frame storage and sequencing
  // ******************************
  rsd_dev_state_type state;
  rsd_dev_state_type next_state;
  logic [TOTAL-1:0] store;
  logic [TOTAL-1:0] next_store;
  logic [SCW-1:0] shiftCnt;
  logic [SCW-1:0] next_shiftCnt;
  logic [TW-1:0] showCnt;
  logic [TW-1:0] next_showCnt;
  logic [LW-1:0] loadCnt;
  logic [LW-1:0] next_loadCnt;
  logic readyN;
  logic next_readyN;
  logic next_loadErr;
  logic next_lit;
  logic [ROWS-1:0] next_rowSink;
  logic [CODE_BITS-1:0] next_colDrive;

  always_comb begin
    next_state = state;
    next_store = store;
    next_shiftCnt = shiftCnt;
    next_showCnt = showCnt;
    next_loadCnt = loadCnt;
    next_loadErr = 1'b0;
    case (state)
      ST_SHIFT: begin
        if (dispTick) begin
          if (shiftCnt == SCW'(SUB)) begin
            // count reached: this falling edge fires the one-shot
            next_state = ST_SHOW;
            next_showCnt = TW'(SHOW_CYCLES - 1);
            next_shiftCnt = '0;
          end else begin
            // circular, so each shift of SUB bits brings the next column in
            next_store = {store[TOTAL-2:0], store[TOTAL-1]};
            next_shiftCnt = shiftCnt + SCW'(1);
          end
        end
      end
      ST_SHOW: begin
        next_shiftCnt = '0;
        if (showCnt == '0) begin
          next_state = ST_SHIFT;
        end else begin
          next_showCnt = showCnt - TW'(1);
        end
      end
      ST_LOAD: begin
        if (entryFall) begin
          // gated input: the only path from the link into storage
          next_store = {store[TOTAL-2:0], dataSync[1]};
          if (loadCnt != LW'(TOTAL + 1)) begin
            next_loadCnt = loadCnt + LW'(1);
          end
        end
        if (!loadReq) begin
          next_state = ST_SHIFT;
          next_shiftCnt = '0;
          // short or long frame leaves the code outside its register
          next_loadErr = (loadCnt != LW'(TOTAL));
        end
      end
      default: begin
        next_state = ST_SHIFT;
      end
    endcase
    if (loadReq && (state != ST_LOAD)) begin
      next_state = ST_LOAD;
      next_shiftCnt = '0;
      next_loadCnt = '0;
    end
    next_readyN = (next_state != ST_LOAD);
    next_lit = (next_state == ST_SHOW);
    // rows sink only while their column is driven
    next_rowSink = next_lit ? next_store[TOTAL-CODE_BITS-1 -: ROWS] : '0;
    next_colDrive = next_lit ? next_store[TOTAL-1 -: CODE_BITS] : '0;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_SHIFT;
      store <= '0;
      shiftCnt <= '0;
      showCnt <= '0;
      loadCnt <= '0;
      readyN <= 1'b1;
      loadErr <= 1'b0;
      lit <= 1'b0;
      rowSink <= '0;
      colDrive <= '0;
    end else begin
      state <= next_state;
      store <= next_store;
      shiftCnt <= next_shiftCnt;
      showCnt <= next_showCnt;
      loadCnt <= next_loadCnt;
      readyN <= next_readyN;
      loadErr <= next_loadErr;
      lit <= next_lit;
      rowSink <= next_rowSink;
      colDrive <= next_colDrive;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign link.readyN = readyN;
  assign loading = ~readyN;

endmodule : rsd_display_end

// ---- core/rsd_host_end.sv ----
// Purpose: host end: buffers user bits and sends them as one load frame
// Assumes: user supplies bits in frame order, column code first per subset
// Notes: entry clock is made here by a divider and driven out
`timescale 1ns/10ps

// two-entry style buffer; depth and width shape the storage
module rsd_buf #(
  parameter int WIDTH = 1,
  parameter int DEPTH = rsd_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic [PW-1:0] next_wrPtr;
  logic [PW-1:0] next_rdPtr;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign inReady = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (push) begin
      next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
    end
    if (pop) begin
      next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
    end
    next_count = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      if (push) begin
        mem[wrPtr] <= inData;
      end
    end
  end
endmodule : rsd_buf

module rsd_host_end #(
  parameter int PACKAGES = rsd_pkg::DEF_PACKAGES,
  parameter int DEPTH = rsd_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // user bit stream
  input wire logic bitValid,
  input wire logic bitData,
  output logic bitReady,
  // status
  output logic busy,
  output logic codeErr,
  // link to display
  rsd_link_if.host_mp link
);
  import rsd_pkg::*;

  localparam int SUB = PKG_BITS * PACKAGES + CODE_BITS;
  localparam int TOTAL = COLUMNS * SUB;
  localparam int BW = $clog2(TOTAL + 1);
  localparam int SW = $clog2(SUB);
  localparam int PW = $clog2(ENTRY_DIV);

  // ******************************
  // buffer and ready sync
  // ******************************
  logic popValid;
  logic popReady;
  logic popData;
  logic [1:0] readySync;
  logic devReady;

  rsd_buf #(.WIDTH(1), .DEPTH(DEPTH)) u_buf (
    .clk(ref_clk),
    .nrst(nrst),
    .inValid(bitValid),
    .inReady(bitReady),
    .inData(bitData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readySync <= 2'h3;
    end else begin
      readySync <= {readySync[0], link.readyN};
    end
  end
  assign devReady = ~readySync[1];

  // ******************************
  // frame sender
  // ******************************
  rsd_host_state_type state;
  rsd_host_state_type next_state;
  logic loadN;
  logic next_loadN;
  logic eclk;
  logic next_eclk;
  logic sdata;
  logic next_sdata;
  logic [PW-1:0] phase;
  logic [PW-1:0] next_phase;
  logic [BW-1:0] bitCnt;
  logic [BW-1:0] next_bitCnt;
  logic [SW-1:0] subCnt;
  logic [SW-1:0] next_subCnt;
  logic [2:0] ones;
  logic [2:0] next_ones;
  logic next_codeErr;

  always_comb begin
    next_state = state;
    next_loadN = loadN;
    next_eclk = eclk;
    next_sdata = sdata;
    next_phase = phase;
    next_bitCnt = bitCnt;
    next_subCnt = subCnt;
    next_ones = ones;
    next_codeErr = 1'b0;
    popReady = 1'b0;
    case (state)
      H_IDLE: begin
        if (popValid) begin
          next_loadN = 1'b0;
          next_state = H_REQ;
        end
      end
      H_REQ: begin
        next_phase = '0;
        next_bitCnt = '0;
        next_subCnt = '0;
        next_ones = '0;
        if (devReady) begin
          next_state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (phase == '0) begin
          if (bitCnt == BW'(TOTAL)) begin
            next_loadN = 1'b1;
            next_state = H_END;
          end else if (popValid) begin
            // an empty buffer simply stretches the entry clock low time
            popReady = 1'b1;
            next_sdata = popData;
            next_eclk = 1'b1;
            next_phase = PW'(1);
            next_subCnt = (subCnt == SW'(SUB - 1)) ? '0 : subCnt + SW'(1);
            if (subCnt < SW'(CODE_BITS)) begin
              next_ones = (subCnt == '0) ? 3'(popData) : ones + 3'(popData);
            end
            if ((subCnt == SW'(CODE_BITS - 1)) && ((ones + 3'(popData)) != 3'h1)) begin
              next_codeErr = 1'b1;
            end
          end
        end else begin
          next_phase = (phase == PW'(ENTRY_DIV - 1)) ? '0 : phase + PW'(1);
          if (next_phase == PW'(ENTRY_HALF)) begin
            // data held steady across the falling edge the display samples
            next_eclk = 1'b0;
            next_bitCnt = bitCnt + BW'(1);
          end
        end
      end
      H_END: begin
        if (!devReady) begin
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= H_IDLE;
      loadN <= 1'b1;
      eclk <= 1'b0;
      sdata <= 1'b0;
      phase <= '0;
      bitCnt <= '0;
      subCnt <= '0;
      ones <= '0;
      codeErr <= 1'b0;
    end else begin
      state <= next_state;
      loadN <= next_loadN;
      eclk <= next_eclk;
      sdata <= next_sdata;
      phase <= next_phase;
      bitCnt <= next_bitCnt;
      subCnt <= next_subCnt;
      ones <= next_ones;
      codeErr <= next_codeErr;
    end
  end

  assign link.loadDataN = loadN;
  assign link.entryClk = eclk;
  assign link.serData = sdata;
  assign busy = (state != H_IDLE);

endmodule : rsd_host_end

// ---- dv/rsd_link_sva.sv ----
// Purpose: link wire checks between host end and display end
// Assumes: both ends run on ref_clk
// Notes: sees the interface wires only
`timescale 1ns/10ps
module rsd_link_sva #(
  parameter int TOTAL_BITS = 165
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link wires
  input wire logic loadDataN,
  input wire logic entryClk,
  input wire logic serData,
  input wire logic readyN
);
  // ********
  // frame bit counter
  // ********
  int fallCnt;
  logic clkQ;
  logic ldQ;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fallCnt <= 0;
      clkQ <= 1'b0;
      ldQ <= 1'b1;
    end else begin
      clkQ <= entryClk;
      ldQ <= loadDataN;
      // cleared at each new request
      if (ldQ && !loadDataN) begin
        fallCnt <= 0;
      end else if (clkQ && !entryClk) begin
        fallCnt <= fallCnt + 1;
      end
    end
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_req;
    $fell(loadDataN);
  endsequence
  sequence s_grant;
    ##[2:6] !readyN;
  endsequence

  a_ready_after_request: assert property (s_req |-> s_grant)
    else $error("ready late after load request");
  a_ready_stands_low: assert property (!loadDataN && !readyN |=> !readyN)
    else $error("ready dropped during load");
  a_ready_released: assert property ($rose(loadDataN) |-> ##[2:6] readyN)
    else $error("ready not released after load");
  a_no_early_shift: assert property (readyN |-> !entryClk)
    else $error("entry clock high without ready");
  a_clock_in_load: assert property ($rose(entryClk) |-> !loadDataN)
    else $error("entry clock outside load");
  a_clock_high_width: assert property ($rose(entryClk) |-> entryClk [*2])
    else $error("entry clock high too short");
  a_clock_low_width: assert property ($fell(entryClk) |-> !entryClk [*2])
    else $error("entry clock low too short");
  a_data_held_fall: assert property ($fell(entryClk) |-> $stable(serData))
    else $error("data moved at sampling edge");
  a_frame_bit_count: assert property ($rose(loadDataN) |=> fallCnt == TOTAL_BITS)
    else $error("wrong bit count in load");
endmodule : rsd_link_sva

// ---- dv/tb_top.sv ----
// Purpose: host end driving display end across the link
// Assumes: one package of four characters, short lit period
// Notes: expectations come from frame layout constants
`timescale 1ns/10ps
module tb_top;
  import rsd_pkg::*;
  localparam int ROWS = PKG_BITS;
  localparam int SUB = ROWS + CODE_BITS;
  localparam int TOTAL = COLUMNS * SUB;
  localparam int SHOW = 40;
  logic ref_clk;
  logic nrst;
  logic bitValid;
  logic bitData;
  logic bitReady;
  logic busy;
  logic codeErr;
  logic [ROWS-1:0] rowSink;
  logic [CODE_BITS-1:0] colDrive;
  logic lit;
  logic loading;
  logic loadErr;
  int error_cnt;
  int tests_run;
  int codeErrs;
  int loadErrs;
  int refusals;

  rsd_link_if link ();
  rsd_host_end #(.PACKAGES(1), .DEPTH(BUF_DEPTH)) i_rsd_host_end (.ref_clk(ref_clk),
    .nrst(nrst), .bitValid(bitValid), .bitData(bitData), .bitReady(bitReady),
    .busy(busy), .codeErr(codeErr), .link(link));
  rsd_display_end #(.PACKAGES(1), .SHOW_CYCLES(SHOW)) i_rsd_display_end (
    .ref_clk(ref_clk), .nrst(nrst), .link(link), .rowSink(rowSink),
    .colDrive(colDrive), .lit(lit), .loading(loading), .loadErr(loadErr));
  rsd_link_sva #(.TOTAL_BITS(TOTAL)) i_rsd_link_sva (.ref_clk(ref_clk), .nrst(nrst),
    .loadDataN(link.loadDataN), .entryClk(link.entryClk), .serData(link.serData),
    .readyN(link.readyN));

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (codeErr === 1'b1) codeErrs++;
    if (loadErr === 1'b1) loadErrs++;
  end

  // ********
  // shared tasks
  // ********
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // w: 0 lit, 1 busy, 2 loading; n counts falling edges waited
  task automatic wait_on(input int w, input logic v, output int n);
    logic s;
    n = 0;
    s = (w == 0) ? lit : (w == 1) ? busy : loading;
    while ((s !== v) && (n < 4000)) begin
      @(negedge ref_clk);
      n++;
      s = (w == 0) ? lit : (w == 1) ? busy : loading;
    end
    if (s !== v) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, s, v);
      give_verdict();
    end
  endtask : wait_on

  // one-hot codes except column 0, which takes code0
  function automatic logic [TOTAL-1:0] make_frame(input logic [6:0] base,
    input logic [4:0] code0);
    logic [TOTAL-1:0] f;
    logic [4:0] cd;
    logic [6:0] r;
    for (int c = 0; c < COLUMNS; c++) begin
      cd = (c == 0) ? code0 : 5'(1 << c);
      r = base + 7'(c * 3);
      f[TOTAL-1-c*SUB -: SUB] = {cd, {CHARS_PER_PKG{r}}};
    end
    return f;
  endfunction : make_frame

  // bit presented at falling edge, taken at next rise if ready
  task automatic send_frame(input logic [TOTAL-1:0] f);
    int i;
    int n;
    i = TOTAL - 1;
    n = 0;
    while (i >= 0) begin
      @(negedge ref_clk);
      bitValid = 1'b1;
      bitData = f[i];
      if (bitReady === 1'b1) i--;
      else refusals++;
      n++;
      if (n > TOTAL * 12) begin
        error_cnt++;
        $display("unexpected at %0t: got %0h expected %0h", $time, n, TOTAL);
        give_verdict();
      end
    end
    @(negedge ref_clk);
    bitValid = 1'b0;
  endtask : send_frame

  // shows subset s of frame f, checks lit length, returns gap before it
  task automatic see_column(input logic [TOTAL-1:0] f, input int s, output int gap);
    logic [SUB-1:0] top;
    int n;
    top = f[TOTAL-1-s*SUB -: SUB];
    wait_on(0, 1'b1, gap);
    @(negedge ref_clk);
    check(32'(colDrive), 32'(top[SUB-1 -: CODE_BITS]));
    check(32'(rowSink), 32'(top[ROWS-1:0]));
    wait_on(0, 1'b0, n);
    check(n + 1, SHOW);
  endtask : see_column

  // ********
  // scenarios
  // ********
  task automatic t_reset_state;
    check(32'(link.readyN), 32'h1);
    check(32'(link.loadDataN), 32'h1);
    check(32'(bitReady), 32'h1);
    check(32'($bits(i_rsd_display_end.rowSink)), 32'(PKG_BITS));
  endtask : t_reset_state

  task automatic t_load_show;
    logic [TOTAL-1:0] f;
    int n;
    int per;
    f = make_frame(7'h2A, 5'h01);
    send_frame(f);
    wait_on(1, 1'b0, n);
    check(32'(refusals > 0), 32'h1);
    check(codeErrs, 0);
    check(loadErrs, 0);
    for (int k = 0; k < COLUMNS; k++) begin
      see_column(f, (k + 1) % COLUMNS, n);
      // tick phase unknown, so allow two display ticks of slack
      if (k > 0) check(32'(n >= SUB * DISP_DIV && n <= (SUB + 2) * DISP_DIV), 32'h1);
      // whole-frame revisit time in ns against the slowest allowed refresh
      per = COLUMNS * (SHOW + n) * CLK_NS;
      if (k > 0) check(32'(per <= 1000000000 / REFRESH_MIN_HZ), 32'h1);
    end
  endtask : t_load_show

  task automatic t_abort_load;
    logic [TOTAL-1:0] f;
    int n;
    int m;
    f = make_frame(7'h55, 5'h03);
    codeErrs = 0;
    wait_on(0, 1'b1, n);
    fork
      send_frame(f);
      begin
        wait_on(2, 1'b1, m);
        @(negedge ref_clk);
        check(32'(lit), 32'h0);
        check(32'(colDrive), 32'h0);
      end
    join
    wait_on(1, 1'b0, n);
    check(codeErrs, 1);
    check(loadErrs, 0);
    see_column(f, 1, n);
  endtask : t_abort_load

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    bitValid = 1'b0;
    bitData = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    codeErrs = 0;
    loadErrs = 0;
    refusals = 0;
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset_state();
    t_load_show();
    t_abort_load();
    give_verdict();
  end
endmodule : tb_top
